/* File: csd_regs.vh */
`ifndef CSD_REGS_VH
`define CSD_REGS_VH
// Channel count and register layout
`define CSD_CHANNELS        8
`define CSD_CH_STRIDE       32'h00000010
`define CSD_OFF_CS          4'h0
`define CSD_OFF_IF0         4'h4
`define CSD_OFF_IF1         4'h8
`define CSD_OFF_IF2         4'hC
`define CSD_OFF_CMD         8'h80
`define CSD_CS_RESET        32'h00000000
// Command codes
`define CSD_CMD_HALT_ALL    32'h00000800
`define CSD_CMD_IGNORE_BIT  31
// Status field positions
`define CSD_FLT_BYTE        24
`define CSD_STATE_BYTE      16
`define CSD_STAT_BYTE       8
`define CSD_LFLT_BYTE       0
`define CSD_STAT_NOT_READY  7
`define CSD_STAT_NO_ID      6
`define CSD_STAT_COM_ERR    5
`define CSD_STAT_RFAULT     0
// Firmware revision from which byte 3 carries remote faults
`define CSD_REV_RFAULT      8'h1D
// Element descriptor encodings
`define CSD_DSC_TYPE        8'hA0
`define CSD_DSC_SIZE_MAX    8'h60
`define CSD_DSC_ETYPE_MAX   8'h07
`define CSD_DIR_IN          8'h00
`define CSD_DIR_BI          8'h40
`define CSD_DIR_OUT         8'h80
`define CSD_PTR_END         16'h0000
`define CSD_STR_END         8'h00
`endif

/* File: csd_mem.v */
`timescale 1ns/1ps
// Small word memory with registered read data
module csd_mem #(
    parameter DW = 32,
    parameter AW = 5
) (
    // Clock
    input  wire          i_clk,
    // Write port
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata,
    // Read port
    input  wire [AW-1:0] i_raddr,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write and registered read; read of a word being written sees old data
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

/* File: csd_bank.v */
// How it works
// - Host mode byte selects remote mode at start
// - Interface word 0 holds unit number
// - Interface word 1 holds name, LSB first
// - Word 2: global pointer high, process low
// - Pointers zero without discovery support
// - Process data overwrites setup data
// - Status readable; normal-mode writes do nothing
// - Byte 3 remote faults from revision 29
// - Byte 2 carries link state code
// - Byte 1 communication status flags
// - Byte 0 sticky local faults, halt clears
// - Byte 3 remote faults after transfer
// - Pointer table ends at zero entry
// - Descriptor header order, record type A0
// - Element size 1 to 96 bits
// - Element type codes 0 to 7
// - Direction codes 00, 40, 80
// - Range fields carried as float words
// - Unit string ends at zero byte
// - Halt-all code stops every channel and clears its faults; mode bytes kept
`timescale 1ns/1ps
`include "csd_regs.vh"
module csd_bank (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [31:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // Command to link engine
    output reg  [31:0] o_cmd,
    output reg         o_cmd_strobe,
    output reg         o_halt_all,
    input  wire        i_cmd_done,
    // Start completion from link engine
    input  wire        i_st_done,
    input  wire [2:0]  i_st_ch,
    input  wire        i_st_setup,
    input  wire        i_st_discovery,
    input  wire [31:0] i_st_unit,
    input  wire [31:0] i_st_name,
    input  wire [15:0] i_st_gptr,
    input  wire [15:0] i_st_pptr,
    input  wire [7:0]  i_st_rfault,
    // Incoming process data
    input  wire        i_pd_we,
    input  wire [2:0]  i_pd_ch,
    input  wire [1:0]  i_pd_word,
    input  wire [31:0] i_pd_data,
    // Transfer completion and link status
    input  wire [7:0]  i_xfer_done,
    input  wire [63:0] i_xfer_rfault,
    input  wire [63:0] i_lfault_set,
    input  wire [31:0] i_stat_flags,
    input  wire [63:0] i_link_state,
    input  wire [7:0]  i_fw_rev,
    // Outgoing process data read port
    input  wire [2:0]  i_out_ch,
    input  wire [1:0]  i_out_word,
    output wire [31:0] o_out_data,
    // Selected remote modes and channel state
    output reg  [63:0] o_mode,
    output reg  [7:0]  o_started,
    // Element descriptor checks
    input  wire        i_dsc_valid,
    input  wire [31:0] i_dsc_hdr,
    output reg         o_dsc_done,
    output reg         o_dsc_ok,
    output reg  [7:0]  o_dsc_size,
    output reg  [7:0]  o_dsc_etype,
    output reg  [7:0]  o_dsc_dir,
    input  wire        i_ptr_valid,
    input  wire [15:0] i_ptr,
    output reg         o_ptr_end,
    input  wire        i_chr_valid,
    input  wire [7:0]  i_chr,
    output reg         o_str_end
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_W0   = 4'b0010;
    localparam ST_W1   = 4'b0100;
    localparam ST_W2   = 4'b1000;

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [2:0]  st_ch;
    reg  [31:0] st_unit;
    reg  [31:0] st_name;
    reg  [31:0] st_ptrs;
    reg  [63:0] lflt;
    reg  [63:0] rflt;
    reg  [7:0]  setup_mode;
    reg         in_we;
    reg  [4:0]  in_waddr;
    reg  [31:0] in_wdata;
    reg  [31:0] cs_word;
    reg  [31:0] next_prdata;
    reg         next_err;
    wire [31:0] in_rdata;
    wire [2:0]  a_ch;
    wire [3:0]  a_off;
    wire [1:0]  a_word;
    wire        a_chan;
    wire        a_cmd;
    wire        a_if;
    wire        acc;
    wire        wr_take;
    wire        out_we;
    wire        halt;
    wire        rev_new;

    // Address decode: channels at 0x00..0x7F, command at 0x80
    assign a_ch    = i_paddr[6:4];
    assign a_off   = i_paddr[3:0];
    assign a_word  = i_paddr[3:2] - 2'h1;
    assign a_chan  = (i_paddr[31:7] == 25'h0000000) &&
                     (i_paddr[1:0] == 2'h0);
    assign a_cmd   = (i_paddr[31:0] == {24'h000000, `CSD_OFF_CMD});
    assign a_if    = a_chan && (a_off != `CSD_OFF_CS);
    assign acc     = i_psel && i_penable;
    assign wr_take = acc && i_pwrite && o_pready;
    assign out_we  = wr_take && a_if;
    assign halt    = wr_take && a_cmd && (i_pwdata == `CSD_CMD_HALT_ALL);
    assign rev_new = (i_fw_rev >= `CSD_REV_RFAULT);

    // Host-written outgoing words, read by the link engine
    csd_mem #(.DW(32), .AW(5)) u_out_mem (
        .i_clk   (i_clk),
        .i_we    (out_we),
        .i_waddr ({a_ch, a_word}),
        .i_wdata (i_pwdata),
        .i_raddr ({i_out_ch, i_out_word}),
        .o_rdata (o_out_data)
    );

    // Incoming words: setup data at start, then process data
    csd_mem #(.DW(32), .AW(5)) u_in_mem (
        .i_clk   (i_clk),
        .i_we    (in_we),
        .i_waddr (in_waddr),
        .i_wdata (in_wdata),
        .i_raddr ({a_ch, a_word}),
        .o_rdata (in_rdata)
    );

    // Per-channel mode, start, sticky local and remote fault state
    genvar g;
    generate
        for (g = 0; g < `CSD_CHANNELS; g = g + 1) begin : g_ch
            wire cs_wr = wr_take && a_chan && (a_ch == g) &&
                         (a_off == `CSD_OFF_CS);
            wire st_hit = i_st_done && (i_st_ch == g);
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_mode[g*8 +: 8] <= 8'h00;
                    o_started[g]     <= 1'b0;
                    setup_mode[g]    <= 1'b0;
                    lflt[g*8 +: 8]   <= 8'h00;
                    rflt[g*8 +: 8]   <= 8'h00;
                end else begin
                    // Mode byte only taken while idle or in setup
                    if (cs_wr && (!o_started[g] || setup_mode[g]))
                        o_mode[g*8 +: 8] <= i_pwdata[31:24];
                    // Set wins over halt so no fault is lost
                    lflt[g*8 +: 8] <= (halt ? 8'h00 : lflt[g*8 +: 8]) |
                                      i_lfault_set[g*8 +: 8];
                    if (halt) begin
                        o_started[g]  <= 1'b0;
                        setup_mode[g] <= 1'b0;
                        rflt[g*8 +: 8] <= 8'h00;
                    end else if (st_hit) begin
                        o_started[g]  <= 1'b1;
                        setup_mode[g] <= i_st_setup;
                        rflt[g*8 +: 8] <= i_st_rfault;
                    end else if (i_xfer_done[g]) begin
                        rflt[g*8 +: 8] <= i_xfer_rfault[g*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // Start sequencer state
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state   <= ST_IDLE;
            st_ch   <= 3'h0;
            st_unit <= 32'h00000000;
            st_name <= 32'h00000000;
            st_ptrs <= 32'h00000000;
        end else begin
            state <= next_state;
            if (i_st_done && (state == ST_IDLE)) begin
                st_ch   <= i_st_ch;
                st_unit <= i_st_unit;
                st_name <= i_st_name;
                st_ptrs <= i_st_discovery ?
                           {i_st_gptr, i_st_pptr} : 32'h00000000;
            end
        end
    end

    // Start data written over three cycles; process data otherwise
    always @* begin
        next_state = ST_IDLE;
        in_we      = i_pd_we;
        in_waddr   = {i_pd_ch, i_pd_word};
        in_wdata   = i_pd_data;
        case (state)
            ST_IDLE: begin
                next_state = (i_st_done && !halt) ? ST_W0 : ST_IDLE;
            end
            ST_W0: begin
                next_state = ST_W1;
                in_we      = 1'b1;
                in_waddr   = {st_ch, 2'h0};
                in_wdata   = st_unit;
            end
            ST_W1: begin
                next_state = ST_W2;
                in_we      = 1'b1;
                in_waddr   = {st_ch, 2'h1};
                in_wdata   = st_name;
            end
            ST_W2: begin
                next_state = ST_IDLE;
                in_we      = 1'b1;
                in_waddr   = {st_ch, 2'h2};
                in_wdata   = st_ptrs;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Status word of the addressed channel
    always @* begin
        cs_word = `CSD_CS_RESET;
        cs_word[`CSD_FLT_BYTE +: 8] =
            rev_new ? rflt[a_ch*8 +: 8] : 8'h00;
        cs_word[`CSD_STATE_BYTE +: 8] = i_link_state[a_ch*8 +: 8];
        cs_word[`CSD_STAT_BYTE + `CSD_STAT_NOT_READY] =
            i_stat_flags[a_ch*4 + 3];
        cs_word[`CSD_STAT_BYTE + `CSD_STAT_NO_ID] =
            i_stat_flags[a_ch*4 + 2];
        cs_word[`CSD_STAT_BYTE + `CSD_STAT_COM_ERR] =
            i_stat_flags[a_ch*4 + 1];
        cs_word[`CSD_STAT_BYTE + `CSD_STAT_RFAULT] =
            i_stat_flags[a_ch*4];
        cs_word[`CSD_LFLT_BYTE +: 8] = lflt[a_ch*8 +: 8];
    end

    // Read data and error select
    always @* begin
        next_prdata = 32'h00000000;
        next_err    = 1'b0;
        if (a_chan && (a_off == `CSD_OFF_CS))
            next_prdata = cs_word;
        else if (a_if)
            next_prdata = in_rdata;
        else if (a_cmd)
            next_prdata = o_cmd;
        else
            next_err = 1'b1;
    end

    // APB answer: ready on second access cycle
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h00000000;
        end else begin
            o_pready  <= acc && !o_pready;
            o_pslverr <= acc && !o_pready && next_err;
            if (acc && !o_pready)
                o_prdata <= i_pwrite ? 32'h00000000 : next_prdata;
        end
    end

    // Command register; a new write wins over completion
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cmd        <= 32'h00000000;
            o_cmd_strobe <= 1'b0;
            o_halt_all   <= 1'b0;
        end else begin
            o_cmd_strobe <= 1'b0;
            o_halt_all   <= halt;
            if (wr_take && a_cmd && !i_pwdata[`CSD_CMD_IGNORE_BIT]) begin
                o_cmd        <= i_pwdata;
                o_cmd_strobe <= 1'b1;
            end else if (i_cmd_done) begin
                o_cmd <= 32'h00000000;
            end
        end
    end

    // Descriptor header, pointer table and string checks
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dsc_done  <= 1'b0;
            o_dsc_ok    <= 1'b0;
            o_dsc_size  <= 8'h00;
            o_dsc_etype <= 8'h00;
            o_dsc_dir   <= 8'h00;
            o_ptr_end   <= 1'b0;
            o_str_end   <= 1'b0;
        end else begin
            o_dsc_done <= i_dsc_valid;
            o_ptr_end  <= i_ptr_valid && (i_ptr == `CSD_PTR_END);
            o_str_end  <= i_chr_valid && (i_chr == `CSD_STR_END);
            if (i_dsc_valid) begin
                o_dsc_size  <= i_dsc_hdr[15:8];
                // Type code tells the host whether the range words apply
                o_dsc_etype <= i_dsc_hdr[23:16];
                o_dsc_dir   <= i_dsc_hdr[31:24];
                o_dsc_ok    <= (i_dsc_hdr[7:0] == `CSD_DSC_TYPE) &&
                    (i_dsc_hdr[15:8] != 8'h00) &&
                    (i_dsc_hdr[15:8] <= `CSD_DSC_SIZE_MAX) &&
                    (i_dsc_hdr[23:16] <= `CSD_DSC_ETYPE_MAX) &&
                    ((i_dsc_hdr[31:24] == `CSD_DIR_IN) ||
                     (i_dsc_hdr[31:24] == `CSD_DIR_BI) ||
                     (i_dsc_hdr[31:24] == `CSD_DIR_OUT));
            end
        end
    end
endmodule

/* File: csd_bank_monitor.sv */
`timescale 1ns/1ps
// Port checks on the channel bank
module csd_bank_chk (
    input wire        i_clk, i_rst_n, i_psel, i_penable, i_pwrite,
    input wire [31:0] i_paddr, i_pwdata, i_dsc_hdr,
    input wire        o_pready, o_pslverr, o_halt_all, o_cmd_strobe,
    input wire        i_dsc_valid, o_dsc_done, o_dsc_ok, i_ptr_valid,
    input wire        o_ptr_end, i_chr_valid, o_str_end,
    input wire [15:0] i_ptr,
    input wire [7:0]  i_chr, o_started
);
    // Command write taken at this edge
    wire cmd = i_psel && i_penable && o_pready && i_pwrite
               && i_paddr == 32'h00000080;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_WAIT_STATE: assert property (i_psel && !i_penable
        |=> !o_pready ##1 o_pready) else $error("late pready");
    AST_ERR_READY: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    AST_HALT: assert property (cmd && i_pwdata == 32'h00000800
        |=> o_halt_all ##0 o_started == 8'h00) else $error("no halt");
    AST_IGNORE: assert property (cmd && i_pwdata[31]
        |=> !o_cmd_strobe && !o_halt_all) else $error("ignore bit obeyed");
    AST_STROBE: assert property (cmd && !i_pwdata[31]
        |=> o_cmd_strobe) else $error("no command strobe");
    AST_PTR_END: assert property (i_ptr_valid && i_ptr == 16'h0000
        |=> o_ptr_end) else $error("missed table end");
    AST_STR_END: assert property (i_chr_valid && i_chr == 8'h00
        |=> o_str_end) else $error("missed string end");
    AST_DSC_TYPE: assert property (i_dsc_valid
        && i_dsc_hdr[7:0] != 8'hA0 |=> o_dsc_done && !o_dsc_ok)
        else $error("bad record type accepted");
    AST_DSC_SIZE: assert property (i_dsc_valid
        && i_dsc_hdr[15:8] > 8'h60 |=> !o_dsc_ok)
        else $error("oversize element accepted");
    COV_HALT: cover property (o_halt_all);
    COV_DSC: cover property (o_dsc_done && o_dsc_ok);
    COV_ERR: cover property (o_pslverr);
endmodule

bind csd_bank csd_bank_chk chk (.*);

/* File: csd_link_model.sv */
`timescale 1ns/1ps
// Link engine and remote device stand-in, driven by bench tasks
module csd_link_model (
    // Clock and command handshake
    input  wire         i_clk,
    input  wire         i_cmd_strobe,
    output reg          o_cmd_done = 1'b0,
    // Start: done, channel, setup, discovery, unit, name, ptrs, fault
    output reg  [109:0] o_st = 110'h0,
    // Process word: write, channel, word, data
    output reg  [37:0]  o_pd = 38'h0,
    // Transfer results and local fault pulses
    output reg  [7:0]   o_xfer_done = 8'h00,
    output reg  [63:0]  o_xfer_rflt = 64'h0,
    output reg  [63:0]  o_lflt_set = 64'h0
);
    // Command completes one cycle after its strobe
    always @(posedge i_clk)
        o_cmd_done <= i_cmd_strobe;
    // Start report; data lines scramble once the pulse is over
    task automatic start(input logic [2:0] ch, input logic su, ds,
                         input logic [95:0] info, input logic [7:0] rf);
        @(posedge i_clk);
        o_st <= {1'b1, ch, su, ds, info, rf};
        @(posedge i_clk);
        o_st <= {1'b0, ~ch, su, ds, ~info, ~rf};
        repeat (4) @(posedge i_clk);
    endtask
    // One incoming process word
    task automatic pd(input logic [2:0] ch, input logic [1:0] w,
                      input logic [31:0] d);
        @(posedge i_clk);
        o_pd <= {1'b1, ch, w, d};
        @(posedge i_clk);
        o_pd <= {1'b0, ~ch, w, ~d};
    endtask
    // Transfer done with its remote fault byte
    task automatic xfer(input logic [2:0] ch, input logic [7:0] rf);
        @(posedge i_clk);
        o_xfer_done[ch] <= 1'b1;
        o_xfer_rflt[ch*8 +: 8] <= rf;
        @(posedge i_clk);
        o_xfer_done <= 8'h00;
        o_xfer_rflt <= ~o_xfer_rflt;
    endtask
    // Local link fault pulse
    task automatic lflt(input logic [2:0] ch, input logic [7:0] f);
        @(posedge i_clk);
        o_lflt_set[ch*8 +: 8] <= f;
        @(posedge i_clk);
        o_lflt_set <= 64'h0;
    endtask
endmodule

/* File: csd_tb.sv */
`timescale 1ns/1ps
// Register-level bench for the channel bank
module tb_top;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0;
    logic        i_penable = 1'b0, i_pwrite = 1'b0, i_dsc_valid = 1'b0;
    logic        i_ptr_valid = 1'b0, i_chr_valid = 1'b0, rerr;
    logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, i_stat_flags = 32'h0;
    logic [31:0] i_dsc_hdr = 32'h0, o_prdata, o_cmd, i_st_unit, rdat;
    logic [31:0] i_st_name, i_pd_data, o_out_data;
    logic [63:0] i_link_state = 64'h0, i_xfer_rfault, i_lfault_set, o_mode;
    logic [7:0]  i_fw_rev = 8'h00, i_chr = 8'h00, i_xfer_done, o_started;
    logic [7:0]  i_st_rfault, o_dsc_size, o_dsc_etype, o_dsc_dir;
    logic [15:0] i_st_gptr, i_st_pptr, i_ptr = 16'h0;
    logic [2:0]  i_st_ch, i_pd_ch, i_out_ch = 3'h0;
    logic [1:0]  i_pd_word, i_out_word = 2'h0;
    logic        o_pready, o_pslverr, o_cmd_strobe, o_halt_all, i_cmd_done;
    logic        i_st_done, i_st_setup, i_st_discovery, i_pd_we;
    logic        o_dsc_done, o_dsc_ok, o_ptr_end, o_str_end;
    int          fail_count = 0, compares = 0;

    csd_bank uut (.*);
    csd_link_model lnk (.i_clk(i_clk), .i_cmd_strobe(o_cmd_strobe),
        .o_cmd_done(i_cmd_done), .o_xfer_done(i_xfer_done),
        .o_st({i_st_done, i_st_ch, i_st_setup, i_st_discovery, i_st_unit,
               i_st_name, i_st_gptr, i_st_pptr, i_st_rfault}),
        .o_pd({i_pd_we, i_pd_ch, i_pd_word, i_pd_data}),
        .o_xfer_rflt(i_xfer_rfault), .o_lflt_set(i_lfault_set));

    // 100 MHz clock
    always #5 i_clk = ~i_clk;

    // Compare a seen value with the expected one
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, bounded wait for pready
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        if (n == 16) fail_count++;
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // Let registered outputs land
    task automatic settle;
        repeat (2) @(posedge i_clk);
    endtask
    // Descriptor header check
    task automatic dsc(input logic [31:0] h, input logic ok);
        @(posedge i_clk);
        i_dsc_valid <= 1'b1;
        i_dsc_hdr <= h;
        @(posedge i_clk);
        i_dsc_valid <= 1'b0;
        #1;
        chk({o_dsc_done, o_dsc_ok}, {1'b1, ok});
        if (ok) chk({o_dsc_dir, o_dsc_etype, o_dsc_size}, h[31:8]);
    endtask
    // Table pointer and string byte terminators
    task automatic term(input logic [15:0] p, input logic [7:0] c);
        @(posedge i_clk);
        i_ptr_valid <= 1'b1;
        i_ptr <= p;
        i_chr_valid <= 1'b1;
        i_chr <= c;
        @(posedge i_clk);
        i_ptr_valid <= 1'b0;
        i_chr_valid <= 1'b0;
        #1;
        chk({o_ptr_end, o_str_end}, {p == 16'h0000, c == 8'h00});
    endtask
    task complete_run;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Test sequence
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(32'h00000000, 32'h00000000);
        rd(32'h00000084, 32'h00000000);
        chk(rerr, 1'b1);
        apb(1'b1, 32'h00000080, 32'h00000800);
        for (int c = 0; c < 8; c++) apb(1'b1, 32'(c) << 4, 32'h0);
        apb(1'b1, 32'h00000010, 32'h05000000);
        settle;
        chk(o_mode[15:8], 8'h05);
        i_fw_rev <= 8'h1C;
        i_link_state <= 64'h3C00;
        i_stat_flags <= 32'hA0;
        lnk.start(3'h1, 1'b0, 1'b1, 96'h00000007_44434241_1234_5678, 8'h81);
        rd(32'h00000014, 32'h00000007);
        rd(32'h00000018, 32'h44434241);
        rd(32'h0000001C, 32'h12345678);
        rd(32'h00000010, 32'h003CA000);
        lnk.lflt(3'h1, 8'hA5);
        i_fw_rev <= 8'h1D;
        i_stat_flags <= 32'h50;
        rd(32'h00000010, 32'h813C41A5);
        apb(1'b1, 32'h00000010, 32'h09000000);
        settle;
        chk(o_mode[15:8], 8'h05);
        lnk.start(3'h2, 1'b1, 1'b0, 96'h00000003_48474645_AAAA_BBBB, 8'h00);
        rd(32'h0000002C, 32'h00000000);
        apb(1'b1, 32'h00000020, 32'h02000000);
        settle;
        chk({o_started[2:1], o_mode[23:16]}, 10'h302);
        $display("test start done");
        apb(1'b1, 32'h00000014, 32'h5A5A0F0F);
        lnk.pd(3'h1, 2'h0, 32'hCAFE0001);
        lnk.xfer(3'h1, 8'h42);
        i_out_ch <= 3'h1;
        rd(32'h00000014, 32'hCAFE0001);
        chk(o_out_data, 32'h5A5A0F0F);
        rd(32'h00000010, 32'h423C41A5);
        $display("test transfer done");
        apb(1'b1, 32'h00000080, 32'h80000800);
        settle;
        chk(o_started[1], 1'b1);
        apb(1'b1, 32'h00000080, 32'h00000800);
        settle;
        chk(o_started, 8'h00);
        rd(32'h00000010, 32'h003C4100);
        rd(32'h00000080, 32'h00000000);
        $display("test halt done");
        for (int e = 0; e < 8; e++) begin
            dsc({8'h00, 8'(e), 8'h60, 8'hA0}, 1'b1);
            dsc({8'h40, 8'(e), 8'h01, 8'hA0}, 1'b1);
            dsc({8'h80, 8'(e), 8'h20, 8'hA0}, 1'b1);
        end
        dsc(32'h000060A1, 1'b0);
        dsc(32'h000061A0, 1'b0);
        dsc(32'h000000A0, 1'b0);
        dsc(32'h000860A0, 1'b0);
        dsc(32'h200160A0, 1'b0);
        term(16'h0002, 8'h6D);
        term(16'h0000, 8'h00);
        $display("test discovery done");
        complete_run;
    end

    // Watchdog for a hung run
    initial begin
        #100000;
        fail_count++;
        complete_run;
    end
endmodule
